// *** rtl/cmgr_top.sv ***
// AXI4-Lite register bank that drives the codec analog mixer gains and power modes
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - DAC coupling bits 5:4 pick shared gain
// - Mic preamp bit 3: 0 20 dB, 1 0 dB
// - Power-down bit set powers whole codec down
// - Sleep bit 0 set enters sleep mode unless power-down bit 1 is set
// - DAC gain: right 7:4, left 3:0, RW
// - Line 1 coupling bits 7:6 pick shared gain
// - Line 1 gains in bits 4:0, two registers
// - Line 2 coupling bits 7:6 pick shared gain
// - Line 2 gains in bits 4:0, two registers
module cmgr_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [cmgr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [cmgr_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [cmgr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [cmgr_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic [3:0] dac_mix_left_gain_o,
  output logic [3:0] dac_mix_right_gain_o,
  output logic [4:0] line1_left_gain_o,
  output logic [4:0] line1_right_gain_o,
  output logic [4:0] line2_left_gain_o,
  output logic [4:0] line2_right_gain_o,
  output logic [4:0] mic_mix_left_gain_o,
  output logic [4:0] mic_mix_right_gain_o,
  output logic mic_preamp_gain_sel_o,
  output logic full_powerdown_o,
  output logic sleep_ctrl_o,
  output logic mixer_active_o
);
  import cmgr_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [NUM_PAIRS-1:0][GAIN_W-1:0] eff_l;
    logic [NUM_PAIRS-1:0][GAIN_W-1:0] eff_r;
    logic mic_sel;
    logic pwrdn;
    logic sleep;
    logic active;
    logic seen;
  } cmgr_state_t;

  cmgr_state_t st_reg;
  cmgr_state_t st_next;

  logic [NUM_REGS-1:0][7:0] bank;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic wr_in_bank;
  logic wr_is_stat;
  logic reg_we;
  logic [32:0] rd_word;
  logic [NUM_PAIRS-1:0][1:0] cpl;
  logic [NUM_PAIRS-1:0][GAIN_W-1:0] raw_l;
  logic [NUM_PAIRS-1:0][GAIN_W-1:0] raw_r;
  logic [NUM_PAIRS-1:0][GAIN_W-1:0] res_l;
  logic [NUM_PAIRS-1:0][GAIN_W-1:0] res_r;

  // ************************************************************
  // Register storage
  // ************************************************************
  cmgr_regfile u_regfile (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .we_i(reg_we),
    .widx_i(st_reg.aw_addr[4:2]),
    .wdata_i(st_reg.w_data),
    .bank_o(bank)
  );

  // ************************************************************
  // Coupling per stereo pair
  // ************************************************************
  // Pair 0 is the DAC mix, pairs 1..3 are line 1, line 2 and mic
  for (genvar k = 0; k < NUM_PAIRS; k++)
  begin : g_pair
    if (k == 0)
    begin : g_dac
      assign cpl[k] = bank[0][DAC_CPL_LSB+:2];
      assign raw_l[k] = {1'b0, bank[1][DAC_L_LSB+:4]};
      assign raw_r[k] = {1'b0, bank[1][DAC_R_LSB+:4]};
    end
    else
    begin : g_five
      assign cpl[k] = bank[2*k][LINE_CPL_LSB+:2];
      assign raw_l[k] = bank[2*k][GAIN_W-1:0];
      assign raw_r[k] = bank[2*k+1][GAIN_W-1:0];
    end
    cmgr_couple #(
      .W(GAIN_W)
    ) u_couple (
      .couple_i(cpl[k]),
      .left_i(raw_l[k]),
      .right_i(raw_r[k]),
      .left_o(res_l[k]),
      .right_o(res_r[k])
    );
  end

  // ************************************************************
  // Bus handshakes
  // ************************************************************
  // Address and data are caught separately, so either may come first
  assign s_axi_awready_o = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready_o = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready_o = !st_reg.rvalid;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

  // Write decode; registers are one byte, so only lane 0 stores
  assign wr_in_bank = (st_reg.aw_addr[ADDR_W-1:5] == '0);
  assign wr_is_stat = (st_reg.aw_addr[ADDR_W-1:2] == OFS_STAT_A[ADDR_W-1:2])
    || (st_reg.aw_addr[ADDR_W-1:2] == OFS_STAT_B[ADDR_W-1:2]);
  assign reg_we = do_write && wr_in_bank && st_reg.w_strb0;

  // Read decode; low address bits are ignored for word alignment
  always_comb
  begin
    rd_word = {1'b0, 32'h0000_0000};
    if (s_axi_araddr_i[ADDR_W-1:5] == '0)
    begin
      rd_word = {1'b1, 24'h00_0000, bank[s_axi_araddr_i[4:2]]};
    end
    else if (s_axi_araddr_i[ADDR_W-1:2] == OFS_STAT_A[ADDR_W-1:2])
    begin
      rd_word = {1'b1, 14'h0000, st_reg.eff_r[1], st_reg.eff_l[1],
        st_reg.eff_r[0][3:0], st_reg.eff_l[0][3:0]};
    end
    else if (s_axi_araddr_i[ADDR_W-1:2] == OFS_STAT_B[ADDR_W-1:2])
    begin
      rd_word = {1'b1, 12'h000, st_reg.eff_r[3], st_reg.eff_l[3],
        st_reg.eff_r[2], st_reg.eff_l[2]};
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.seen = 1'b1;
    // Write address and data capture
    if (aw_hs)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (w_hs)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata_i[7:0];
      st_next.w_strb0 = s_axi_wstrb_i[0];
    end
    // Response after both halves are in; status words ignore writes
    if (do_write)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = (wr_in_bank || wr_is_stat) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid = 1'b0;
    end
    // Read data are latched at the handshake and held until taken
    if (ar_hs)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_word[31:0];
      st_next.rresp = rd_word[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
    end
    // Mixer controls follow the registers one cycle later
    st_next.eff_l = res_l;
    st_next.eff_r = res_r;
    st_next.mic_sel = bank[0][MIC_SEL_BIT];
    st_next.pwrdn = bank[0][PWRDN_BIT];
    // Complete power-down outranks sleep
    st_next.sleep = bank[0][SLEEP_BIT] && !bank[0][PWRDN_BIT];
    st_next.active = !bank[0][SLEEP_BIT] && !bank[0][PWRDN_BIT];
  end

  // State register; mixer outputs reset to the register reset image
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_reg <= '0;
      st_reg.eff_l <= {RST_GAIN5[4:0], RST_GAIN5[4:0], RST_GAIN5[4:0], 5'h00};
      st_reg.eff_r <= {RST_GAIN5[4:0], RST_GAIN5[4:0], RST_GAIN5[4:0], 5'h00};
      st_reg.active <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o = st_reg.rdata;
  assign s_axi_rresp_o = st_reg.rresp;
  assign dac_mix_left_gain_o = st_reg.eff_l[0][3:0];
  assign dac_mix_right_gain_o = st_reg.eff_r[0][3:0];
  assign line1_left_gain_o = st_reg.eff_l[1];
  assign line1_right_gain_o = st_reg.eff_r[1];
  assign line2_left_gain_o = st_reg.eff_l[2];
  assign line2_right_gain_o = st_reg.eff_r[2];
  assign mic_mix_left_gain_o = st_reg.eff_l[3];
  assign mic_mix_right_gain_o = st_reg.eff_r[3];
  assign mic_preamp_gain_sel_o = st_reg.mic_sel;
  assign full_powerdown_o = st_reg.pwrdn;
  assign sleep_ctrl_o = st_reg.sleep;
  assign mixer_active_o = st_reg.active;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_dac_couple_right;
    (cpl[0] == CPL_RIGHT) |=> (dac_mix_left_gain_o == $past(bank[1][7:4]))
      && (dac_mix_right_gain_o == $past(bank[1][7:4]));
  endproperty
  a_dac_couple_right: assert property (p_dac_couple_right)
    else $error("DAC coupling 01 did not share the right gain");

  property p_mic_sel_write;
    (reg_we && st_reg.aw_addr == OFS_CTRL) |=> ##1
      (mic_preamp_gain_sel_o == $past(st_reg.w_data[MIC_SEL_BIT], 2));
  endproperty
  a_mic_sel_write: assert property (p_mic_sel_write)
    else $error("Mic preamp select did not follow the written bit");

  property p_powerdown_wins;
    full_powerdown_o |-> (!mixer_active_o && !sleep_ctrl_o);
  endproperty
  a_powerdown_wins: assert property (p_powerdown_wins)
    else $error("Power-down left the mixer active or in sleep");

  property p_sleep_write;
    (reg_we && st_reg.aw_addr == OFS_CTRL && !st_reg.w_data[PWRDN_BIT]) |=> ##1
      (sleep_ctrl_o == $past(st_reg.w_data[SLEEP_BIT], 2))
      && (mixer_active_o == !$past(st_reg.w_data[SLEEP_BIT], 2));
  endproperty
  a_sleep_write: assert property (p_sleep_write)
    else $error("Sleep output did not follow the written bit");

  property p_dac_readback;
    (reg_we && st_reg.aw_addr == OFS_DAC_GAIN) |=> (bank[1] == $past(st_reg.w_data));
  endproperty
  a_dac_readback: assert property (p_dac_readback)
    else $error("DAC gain register lost written bits");

  property p_line1_couple;
    (cpl[1] == CPL_INDEP) |=> (line1_left_gain_o == $past(bank[2][4:0]))
      && (line1_right_gain_o == $past(bank[3][4:0]));
  endproperty
  a_line1_couple: assert property (p_line1_couple)
    else $error("Line 1 independent gains not passed through");

  property p_line1_store;
    (reg_we && st_reg.aw_addr == OFS_LINE1_L) |=>
      (bank[2] == ($past(st_reg.w_data) & MASK_CPL_GAIN)) && !bank[2][5];
  endproperty
  a_line1_store: assert property (p_line1_store)
    else $error("Line 1 left register stored wrong bits");

  property p_line2_couple_left;
    cpl[2][1] |=> (line2_right_gain_o == $past(bank[4][4:0]))
      && (line2_left_gain_o == $past(bank[4][4:0]));
  endproperty
  a_line2_couple_left: assert property (p_line2_couple_left)
    else $error("Line 2 coupling 1x did not share the left gain");

  property p_line2_right_reserved;
    (bank[5][7:5] == 3'h0) && (bank[7][7:5] == 3'h0);
  endproperty
  a_line2_right_reserved: assert property (p_line2_right_reserved)
    else $error("Right gain register reserved bits set");

  property p_mic_couple;
    (cpl[3] == CPL_INDEP) |=> (mic_mix_left_gain_o == $past(bank[6][4:0]));
  endproperty
  a_mic_couple: assert property (p_mic_couple)
    else $error("Mic left gain not passed through");

  property p_reset_values;
    !st_reg.seen |-> (bank[2] == RST_GAIN5) && (bank[6] == RST_GAIN5)
      && (bank[1] == RST_DAC);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Gain registers did not reset to their defaults");

  // Main scenarios
  c_write_done: cover property (do_write ##1 s_axi_bvalid_o);
  c_read_stat: cover property (ar_hs && s_axi_araddr_i == OFS_STAT_A);
  c_sleep: cover property (sleep_ctrl_o && !full_powerdown_o);
  c_bad_addr: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);

endmodule : cmgr_top

// *** rtl/cmgr_pkg.sv ***
// Package of offsets, fields, reset values and masks for the codec mixing gain registers
package cmgr_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 8;
  localparam int NUM_PAIRS = 4;
  localparam int GAIN_W = 5;

  // ************************************************************
  // Byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DAC_GAIN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LINE1_L = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LINE1_R = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LINE2_L = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE2_R = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MIC_L = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MIC_R = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STAT_A = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STAT_B = 8'h24;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DAC_CPL_LSB = 4;
  localparam int LINE_CPL_LSB = 6;
  localparam int MIC_SEL_BIT = 3;
  localparam int PWRDN_BIT = 1;
  localparam int SLEEP_BIT = 0;
  localparam int DAC_R_LSB = 4;
  localparam int DAC_L_LSB = 0;

  // Coupling codes; 10 and 11 both select the left value
  localparam logic [1:0] CPL_INDEP = 2'h0;
  localparam logic [1:0] CPL_RIGHT = 2'h1;

  // ************************************************************
  // Reset values and writable masks
  // ************************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DAC = 8'h00;
  localparam logic [7:0] RST_GAIN5 = 8'h04;
  localparam logic [7:0] MASK_CTRL = 8'h3B;
  localparam logic [7:0] MASK_DAC = 8'hFF;
  localparam logic [7:0] MASK_CPL_GAIN = 8'hDF;
  localparam logic [7:0] MASK_GAIN = 8'h1F;
  localparam logic [NUM_REGS-1:0][7:0] REG_RST = {RST_GAIN5, RST_GAIN5, RST_GAIN5, RST_GAIN5,
    RST_GAIN5, RST_GAIN5, RST_DAC, RST_CTRL};
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {MASK_GAIN, MASK_CPL_GAIN, MASK_GAIN,
    MASK_CPL_GAIN, MASK_GAIN, MASK_CPL_GAIN, MASK_DAC, MASK_CTRL};

  // ************************************************************
  // Bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmgr_pkg

// *** rtl/cmgr_couple.sv ***
// Left/right gain coupling resolver for one stereo pair
`timescale 1ns/1ps
module cmgr_couple #(
  parameter int W = 5
) (
  input wire logic [1:0] couple_i,
  input wire logic [W-1:0] left_i,
  input wire logic [W-1:0] right_i,
  output logic [W-1:0] left_o,
  output logic [W-1:0] right_o
);
  import cmgr_pkg::*;

  // ************************************************************
  // Gain selection
  // ************************************************************
  // Only 00 keeps the channels apart; any code with the high bit set follows left
  always_comb
  begin
    left_o = left_i;
    right_o = right_i;
    if (couple_i == CPL_RIGHT)
    begin
      left_o = right_i;
    end
    else if (couple_i != CPL_INDEP)
    begin
      right_o = left_i;
    end
  end

endmodule : cmgr_couple

// *** rtl/cmgr_regfile.sv ***
// Eight-byte storage for the mixing gain and mode registers
`timescale 1ns/1ps
module cmgr_regfile (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [2:0] widx_i,
  input wire logic [7:0] wdata_i,
  output logic [cmgr_pkg::NUM_REGS-1:0][7:0] bank_o
);
  import cmgr_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] bank;
  } cmgr_rf_state_t;

  cmgr_rf_state_t st_reg;
  cmgr_rf_state_t st_next;

  // ************************************************************
  // Write path
  // ************************************************************
  // Reserved bits are masked on write so they always read back as zero
  always_comb
  begin
    st_next = st_reg;
    if (we_i)
    begin
      st_next.bank[widx_i] = wdata_i & REG_MASK[widx_i];
    end
  end

  // Storage with per-register reset values
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_reg <= cmgr_rf_state_t'(REG_RST);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bank_o = st_reg.bank;

endmodule : cmgr_regfile

// *** verif/tb_cmgr_top.sv ***
// Self-checking bench for the codec mixing gain register bank
`timescale 1ns/1ps
module tb_cmgr_top;
  import cmgr_pkg::*;

  // ************************************************************
  // Signals and stimulus table
  // ************************************************************
  logic clk_i;
  logic reset_n_i;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, dac_l, dac_r;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] l1_l, l1_r, l2_l, l2_r, mic_l, mic_r;
  logic mic_sel, pwrdn, sleep, active;
  logic [7:0] shadow [8];
  logic [31:0] stat_a, stat_b;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  typedef struct packed {logic [7:0] addr; logic [7:0] data;} cmgr_row_t;
  // Address and data of each write; the readback is the data under the writable mask
  cmgr_row_t rows [21] = '{'{8'h04, 8'hA5}, '{8'h00, 8'h10}, '{8'h00, 8'h20}, '{8'h00, 8'h30},
    '{8'h00, 8'h08}, '{8'h00, 8'h02}, '{8'h00, 8'h03}, '{8'h00, 8'hFD}, '{8'h00, 8'h00},
    '{8'h08, 8'h33}, '{8'h0C, 8'hE7}, '{8'h08, 8'h53}, '{8'h08, 8'h93}, '{8'h08, 8'hD3},
    '{8'h10, 8'h4E}, '{8'h14, 8'h19}, '{8'h10, 8'h8E}, '{8'h18, 8'h1F}, '{8'h1C, 8'h02},
    '{8'h18, 8'h5F}, '{8'h18, 8'hDF}};

  cmgr_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .dac_mix_left_gain_o(dac_l), .dac_mix_right_gain_o(dac_r),
    .line1_left_gain_o(l1_l), .line1_right_gain_o(l1_r), .line2_left_gain_o(l2_l),
    .line2_right_gain_o(l2_r), .mic_mix_left_gain_o(mic_l), .mic_mix_right_gain_o(mic_r),
    .mic_preamp_gain_sel_o(mic_sel), .full_powerdown_o(pwrdn), .sleep_ctrl_o(sleep),
    .mixer_active_o(active));

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Whole run needs well under a thousand cycles, so a hang ends here
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Resolved pair {left, right}: 00 own values, 01 right on both, 1x left on both
  function automatic logic [9:0] pair(input logic [1:0] c, input logic [4:0] l,
    input logic [4:0] r);
    if (c == 2'h0)
      return {l, r};
    if (c == 2'h1)
      return {r, r};
    return {l, l};
  endfunction : pair

  // Compare every mixer output with the shadow copy, mid-cycle where all has settled
  task automatic check_outs();
    logic [7:0] c;
    logic [9:0] d, a, b, m;
    c = shadow[0];
    d = pair(c[5:4], {1'b0, shadow[1][3:0]}, {1'b0, shadow[1][7:4]});
    a = pair(shadow[2][7:6], shadow[2][4:0], shadow[3][4:0]);
    b = pair(shadow[4][7:6], shadow[4][4:0], shadow[5][4:0]);
    m = pair(shadow[6][7:6], shadow[6][4:0], shadow[7][4:0]);
    // Status words carry the resolved gains, right above left, lowest pair first
    stat_a = {14'h0, a[4:0], a[9:5], d[3:0], d[8:5]};
    stat_b = {12'h0, m[4:0], m[9:5], b[4:0], b[9:5]};
    @(negedge clk_i);
    check("dac_mix", {24'h0, dac_l, dac_r}, {24'h0, d[8:5], d[3:0]});
    check("line1_mix", {22'h0, l1_l, l1_r}, {22'h0, a});
    check("line2_mix", {22'h0, l2_l, l2_r}, {22'h0, b});
    check("mic_mix", {22'h0, mic_l, mic_r}, {22'h0, m});
    check("mode", {28'h0, mic_sel, pwrdn, sleep, active},
      {28'h0, c[3], c[1], c[0] & ~c[1], ~c[0] & ~c[1]});
    @(posedge clk_i);
  endtask : check_outs

  // ************************************************************
  // Bus master tasks: handshakes judged mid-cycle, released after the edge
  // ************************************************************
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    // A fresh edge keeps bready from being lowered and raised in one step
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t)
    begin
      @(negedge clk_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      r = bresp;
      @(posedge clk_i);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
        bready <= 1'b0;
    end
    // The answer must not overtake either half of the request
    check("write_taken", {30'h0, awvalid, wvalid}, 32'h0);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    // A fresh edge keeps rready from being lowered and raised in one step
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t)
    begin
      @(negedge clk_i);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
        rready <= 1'b0;
    end
    // Read data may only come once the address was taken
    check("read_taken", {31'h0, arvalid}, 32'h0);
  endtask : axi_read

  // Reset contents: mode and DAC gain clear, every five-bit gain 0x04
  task automatic reset_check();
    foreach (shadow[k])
      shadow[k] = (k < 2) ? 8'h00 : 8'h04;
    check_outs();
    for (int k = 0; k < 8; k++)
    begin
      axi_read(8'(k * 4), rd, resp);
      check("reset_value", rd, {24'h0, shadow[k]});
    end
  endtask : reset_check

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    reset_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reset_check();
    // Table: write, watch the mixer outputs, read back
    foreach (rows[i])
    begin
      axi_write(rows[i].addr, rows[i].data, resp);
      check("write_resp", {30'h0, resp}, {30'h0, RESP_OKAY});
      shadow[rows[i].addr[4:2]] = rows[i].data & REG_MASK[rows[i].addr[4:2]];
      check_outs();
      axi_read(rows[i].addr, rd, resp);
      check("readback", rd, {24'h0, shadow[rows[i].addr[4:2]]});
    end
    // Status words mirror the resolved gains; writes there are answered and ignored
    axi_write(OFS_STAT_A, 8'hFF, resp);
    check("stat_wr", {30'h0, resp}, {30'h0, RESP_OKAY});
    check_outs();
    axi_read(OFS_STAT_A, rd, resp);
    check("stat_a", rd, stat_a);
    axi_read(OFS_STAT_B, rd, resp);
    check("stat_b", rd, stat_b);
    // Unmapped place: refused, nothing stored, reads zero
    axi_write(8'h40, 8'hFF, resp);
    check("unmapped_wr", {30'h0, resp}, {30'h0, RESP_SLVERR});
    check_outs();
    axi_read(8'h40, rd, resp);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    // Byte lane off: accepted but the DAC gain keeps its value
    wstrb <= 4'h0;
    axi_write(8'h04, 8'h3C, resp);
    check("no_strobe_resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    wstrb <= 4'hF;
    axi_read(8'h04, rd, resp);
    check("no_strobe", rd, {24'h0, shadow[1]});
    // Second reset in mid-run must restore every value
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reset_check();
    test_done();
  end

endmodule : tb_cmgr_top
